// ---- logic/prl_pkg.sv ----
// Constants, register map and rate table for the port 2 rate limiter
package prl_pkg;
  // Register offsets (byte addresses)
  localparam logic [15:0] ING_RATE_OFS = 16'h0528;
  localparam logic [15:0] EG_RATE_OFS = 16'h052a;
  localparam logic [15:0] CFG_OFS = 16'h0540;
  localparam logic [15:0] STATUS_OFS = 16'h0542;
  // Reset values
  localparam logic [15:0] ING_RATE_RST = 16'h0000;
  localparam logic [15:0] EG_RATE_RST = 16'h0000;
  localparam logic [4:0] CFG_RST = 5'h10;
  // Rate field p sits at bits p*RATE_FIELD_W upward
  localparam int RATE_FIELD_W = 4;
  localparam int NUM_PRIO = 4;
  // Configuration register fields
  localparam int CFG_PRE_BIT = 0;
  localparam int CFG_IFG_BIT = 1;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_MQ_BIT = 4;
  localparam int CFG_W = 5;
  // Ingress limit modes
  localparam logic [1:0] MODE_ALL = 2'h0;
  localparam logic [1:0] MODE_BMF = 2'h1;
  localparam logic [1:0] MODE_BM = 2'h2;
  localparam logic [1:0] MODE_B = 2'h3;
  // Framing overhead in bytes
  localparam int IFG_BYTES = 12;
  localparam int PREAMBLE_BYTES = 8;
  // Timing: credit unit is 1e-5 bit per kbps per clock
  localparam int CLK_HZ = 100_000_000;
  localparam int CHARGE_PER_BYTE = 8 * (CLK_HZ / 1000);
  localparam int BURST_BYTES = 2048;
  localparam int CRED_W = 34;
  localparam logic signed [CRED_W-1:0] CRED_CAP = CRED_W'(BURST_BYTES * CHARGE_PER_BYTE);
  localparam logic [3:0] SPEED10_MAX_CODE = 4'h8;
  localparam int KBPS_W = 17;

  // Rate code to kbps; zero means no limit
  function automatic logic [KBPS_W-1:0] prl_rate_kbps(input logic [3:0] code, input logic speed_10m);
    logic [KBPS_W-1:0] k;
    k = '0;
    case (code)
      4'h1: k = 17'd64;
      4'h2: k = 17'd128;
      4'h3: k = 17'd256;
      4'h4: k = 17'd512;
      4'h5: k = 17'd1000;
      4'h6: k = 17'd2000;
      4'h7: k = 17'd4000;
      4'h8: k = 17'd8000;
      4'h9: k = 17'd16000;
      4'ha: k = 17'd32000;
      4'hb: k = 17'd48000;
      4'hc: k = 17'd64000;
      4'hd: k = 17'd72000;
      4'he: k = 17'd80000;
      4'hf: k = 17'd88000;
      default: k = '0;
    endcase
    if (speed_10m && code > SPEED10_MAX_CODE) begin
      k = '0;
    end
    return k;
  endfunction : prl_rate_kbps
endpackage : prl_pkg

// ---- logic/prl_fifo.sv ----
// Small flip-flop FIFO with valid/ready on both sides
module prl_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULLC = CW'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic room_reg, room_next, empty_reg, empty_next;
  logic push, pop;

  assign in_ready = room_reg; // Ready straight from a flop
  assign out_valid = !empty_reg;
  assign out_data = mem_reg[rd_reg];
  assign push = in_valid && room_reg;
  assign pop = out_ready && !empty_reg;

  // Next pointers, count and flags
  always_comb begin
    mem_next = mem_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      mem_next[wr_reg] = in_data;
      wr_next = (wr_reg == LAST) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == LAST) ? '0 : rd_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
    room_next = (cnt_next != FULLC);
    empty_next = (cnt_next == '0);
  end

  // State registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      room_reg <= 1'b1;
      empty_reg <= 1'b1;
    end else begin
      mem_reg <= mem_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      room_reg <= room_next;
      empty_reg <= empty_next;
    end
  end

  never_overfill_a: assert property (@(posedge clk_sys) disable iff (!resetn) cnt_reg <= FULLC)
    else $error("fifo count above depth");
endmodule : prl_fifo

// ---- logic/prl_port_rate_limiter.sv ----
// Port 2 ingress policing and egress shaping per priority
// Behaviour
// - Police priority 3 ingress with bits 15:12
// - Police priority 2 ingress with bits 11:8
// - Police priority 1 ingress with bits 7:4
// - Police priority 0 ingress with bits 3:0
// - Code zero means unlimited, reset value
// - Nonzero codes map to fixed rate table
// - At 10 Mbps, codes above 10M unlimited
// - Shape priority 3 egress with bits 15:12
// - Shape priority 2 egress with bits 11:8
// - Egress holds frames back, never drops
// - Single queue: only priority 0 egress field applies
// - Shape priority 1 egress with bits 7:4
// - Shape priority 0 egress with bits 3:0
// - Limit mode selects which ingress frames count
module prl_port_rate_limiter
  import prl_pkg::*;
#(
  parameter int LEN_W = 11,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic speed_10m,
  input wire logic rx_frm_valid,
  input wire logic [LEN_W-1:0] rx_frm_len,
  input wire logic [1:0] rx_frm_prio,
  input wire logic rx_frm_bcast,
  input wire logic rx_frm_mcast,
  input wire logic rx_frm_flood,
  output logic rx_dec_valid,
  output logic rx_dec_drop,
  input wire logic tx_in_valid,
  output logic tx_in_ready,
  input wire logic [LEN_W-1:0] tx_in_len,
  input wire logic [1:0] tx_in_prio,
  output logic tx_out_valid,
  input wire logic tx_out_ready,
  output logic [LEN_W-1:0] tx_out_len,
  output logic [1:0] tx_out_prio
);
  localparam int DW = LEN_W + 2;

  // Software-visible state
  logic [15:0] port2_ingress_rate_ctrl_reg, port2_ingress_rate_ctrl_next;
  logic [15:0] port2_egress_rate_ctrl_reg, port2_egress_rate_ctrl_next;
  logic [CFG_W-1:0] cfg_reg, cfg_next;
  logic [15:0] rdata_reg, rdata_next;
  // Frame path state
  logic rx_dec_valid_reg, rx_dec_valid_next, rx_dec_drop_reg, rx_dec_drop_next;
  logic tx_out_valid_reg, tx_out_valid_next;
  logic [LEN_W-1:0] tx_out_len_reg, tx_out_len_next;
  logic [1:0] tx_out_prio_reg, tx_out_prio_next;
  logic signed [CRED_W-1:0] ing_cred_reg [NUM_PRIO];
  logic signed [CRED_W-1:0] ing_cred_next [NUM_PRIO];
  logic signed [CRED_W-1:0] eg_cred_reg [NUM_PRIO];
  logic signed [CRED_W-1:0] eg_cred_next [NUM_PRIO];
  // Combinational helpers
  logic [KBPS_W-1:0] ing_kbps [NUM_PRIO];
  logic [KBPS_W-1:0] eg_kbps [NUM_PRIO];
  logic [NUM_PRIO-1:0] ing_charge, eg_charge, eg_ok;
  logic rx_counted, rx_limited, rx_drop, fifo_valid, fifo_pop, multi_q;
  logic [DW-1:0] fifo_data;
  logic [1:0] mode, eg_sel_prio;
  logic [LEN_W-1:0] fifo_len;
  logic [15:0] status;
  logic [31:0] rx_cost, tx_cost;

  assign mode = cfg_reg[CFG_MODE_LSB +: 2];
  assign multi_q = cfg_reg[CFG_MQ_BIT];
  assign fifo_len = fifo_data[LEN_W-1:0];

  // Credit charged per frame: bytes including optional overhead, times CHARGE_PER_BYTE
  function automatic logic [31:0] frame_cost(input logic [LEN_W-1:0] len, input logic [CFG_W-1:0] cfg);
    logic [31:0] b;
    b = 32'(len);
    if (cfg[CFG_IFG_BIT]) begin
      b = b + 32'(IFG_BYTES);
    end
    if (cfg[CFG_PRE_BIT]) begin
      b = b + 32'(PREAMBLE_BYTES);
    end
    return b * 32'(CHARGE_PER_BYTE);
  endfunction : frame_cost

  assign rx_cost = frame_cost(rx_frm_len, cfg_reg);
  assign tx_cost = frame_cost(fifo_len, cfg_reg);

  // Which ingress frames are subject to the limit
  always_comb begin
    case (mode)
      MODE_ALL: rx_counted = 1'b1;
      MODE_BMF: rx_counted = rx_frm_bcast || rx_frm_mcast || rx_frm_flood;
      MODE_BM: rx_counted = rx_frm_bcast || rx_frm_mcast;
      MODE_B: rx_counted = rx_frm_bcast;
      default: rx_counted = 1'b1;
    endcase
  end

  // Ingress verdict: drop once the bucket is spent
  assign rx_limited = rx_counted && (ing_kbps[rx_frm_prio] != '0);
  assign rx_drop = rx_limited && ing_cred_reg[rx_frm_prio][CRED_W-1];

  // Egress queue selection; one queue maps all traffic to priority 0
  assign eg_sel_prio = multi_q ? fifo_data[DW-1 -: 2] : 2'h0;
  assign fifo_pop = fifo_valid && (!tx_out_valid_reg || tx_out_ready) && eg_ok[eg_sel_prio];

  // Per-priority credit buckets
  genvar p;
  generate
    for (p = 0; p < NUM_PRIO; p++) begin : g_prio
      assign ing_kbps[p] = prl_rate_kbps(port2_ingress_rate_ctrl_reg[p*RATE_FIELD_W +: RATE_FIELD_W],
        speed_10m);
      assign eg_kbps[p] = prl_rate_kbps(port2_egress_rate_ctrl_reg[p*RATE_FIELD_W +: RATE_FIELD_W], speed_10m);
      assign eg_ok[p] = (eg_kbps[p] == '0) || !eg_cred_reg[p][CRED_W-1];
      assign ing_charge[p] = rx_frm_valid && (rx_frm_prio == p) && rx_limited && !rx_drop;
      assign eg_charge[p] = fifo_pop && (eg_sel_prio == p);

      // Refill at the selected rate, charge accepted frames, clamp at cap
      always_comb begin
        ing_cred_next[p] = ing_cred_reg[p] + $signed({{(CRED_W-KBPS_W){1'b0}}, ing_kbps[p]});
        if (ing_cred_next[p] > CRED_CAP || ing_kbps[p] == '0) begin
          ing_cred_next[p] = CRED_CAP;
        end
        if (ing_charge[p]) begin
          ing_cred_next[p] = ing_cred_next[p] - $signed({2'b00, rx_cost});
        end
        eg_cred_next[p] = eg_cred_reg[p] + $signed({{(CRED_W-KBPS_W){1'b0}}, eg_kbps[p]});
        if (eg_cred_next[p] > CRED_CAP || eg_kbps[p] == '0) begin
          eg_cred_next[p] = CRED_CAP;
        end
        if (eg_charge[p] && eg_kbps[p] != '0) begin
          eg_cred_next[p] = eg_cred_next[p] - $signed({2'b00, tx_cost});
        end
      end

      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          ing_cred_reg[p] <= CRED_CAP;
          eg_cred_reg[p] <= CRED_CAP;
        end else begin
          ing_cred_reg[p] <= ing_cred_next[p];
          eg_cred_reg[p] <= eg_cred_next[p];
        end
      end

      cred_capped_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        ing_cred_reg[p] <= CRED_CAP && eg_cred_reg[p] <= CRED_CAP)
        else $error("credit above cap");

      // Charging a frame must spend credit
      ing_spend_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        ing_charge[p] && rx_cost > 32'(ing_kbps[p]) |=> ing_cred_reg[p] < $past(ing_cred_reg[p]))
        else $error("ingress charge not spent");
      eg_spend_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        eg_charge[p] && eg_kbps[p] != '0 && tx_cost > 32'(eg_kbps[p]) |=> eg_cred_reg[p] < $past(eg_cred_reg[p]))
        else $error("egress charge not spent");
    end
  endgenerate

  // Live status: bit p ingress spent, bit 4+p egress spent, bit 8 fifo full
  assign status = {7'h00, !tx_in_ready,
    eg_cred_reg[3][CRED_W-1], eg_cred_reg[2][CRED_W-1], eg_cred_reg[1][CRED_W-1], eg_cred_reg[0][CRED_W-1],
    ing_cred_reg[3][CRED_W-1], ing_cred_reg[2][CRED_W-1], ing_cred_reg[1][CRED_W-1], ing_cred_reg[0][CRED_W-1]};

  // Register writes and one-cycle read data
  always_comb begin
    port2_ingress_rate_ctrl_next = port2_ingress_rate_ctrl_reg;
    port2_egress_rate_ctrl_next = port2_egress_rate_ctrl_reg;
    cfg_next = cfg_reg;
    rdata_next = '0;
    if (reg_wr) begin
      case (reg_addr)
        ING_RATE_OFS: port2_ingress_rate_ctrl_next = reg_wdata;
        EG_RATE_OFS: port2_egress_rate_ctrl_next = reg_wdata;
        CFG_OFS: cfg_next = reg_wdata[CFG_W-1:0];
        default: cfg_next = cfg_reg;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ING_RATE_OFS: rdata_next = port2_ingress_rate_ctrl_reg;
        EG_RATE_OFS: rdata_next = port2_egress_rate_ctrl_reg;
        CFG_OFS: rdata_next = {{(16-CFG_W){1'b0}}, cfg_reg};
        STATUS_OFS: rdata_next = status;
        default: rdata_next = '0;
      endcase
    end
  end

  // Frame path next state
  always_comb begin
    rx_dec_valid_next = rx_frm_valid;
    rx_dec_drop_next = rx_frm_valid && rx_drop;
    tx_out_valid_next = tx_out_valid_reg && !tx_out_ready;
    tx_out_len_next = tx_out_len_reg;
    tx_out_prio_next = tx_out_prio_reg;
    if (fifo_pop) begin
      tx_out_valid_next = 1'b1;
      tx_out_len_next = fifo_len;
      tx_out_prio_next = fifo_data[DW-1 -: 2];
    end
  end

  // Registers of the top level other than the credit buckets
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      port2_ingress_rate_ctrl_reg <= ING_RATE_RST;
      port2_egress_rate_ctrl_reg <= EG_RATE_RST;
      cfg_reg <= CFG_RST;
      rdata_reg <= '0;
      rx_dec_valid_reg <= 1'b0;
      rx_dec_drop_reg <= 1'b0;
      tx_out_valid_reg <= 1'b0;
      tx_out_len_reg <= '0;
      tx_out_prio_reg <= '0;
    end else begin
      port2_ingress_rate_ctrl_reg <= port2_ingress_rate_ctrl_next;
      port2_egress_rate_ctrl_reg <= port2_egress_rate_ctrl_next;
      cfg_reg <= cfg_next;
      rdata_reg <= rdata_next;
      rx_dec_valid_reg <= rx_dec_valid_next;
      rx_dec_drop_reg <= rx_dec_drop_next;
      tx_out_valid_reg <= tx_out_valid_next;
      tx_out_len_reg <= tx_out_len_next;
      tx_out_prio_reg <= tx_out_prio_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign rx_dec_valid = rx_dec_valid_reg;
  assign rx_dec_drop = rx_dec_drop_reg;
  assign tx_out_valid = tx_out_valid_reg;
  assign tx_out_len = tx_out_len_reg;
  assign tx_out_prio = tx_out_prio_reg;

  // Egress descriptor buffer
  prl_fifo #(
    .WIDTH(DW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .in_valid(tx_in_valid),
    .in_ready(tx_in_ready),
    .in_data({tx_in_prio, tx_in_len}),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  spent_drops_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    rx_frm_valid && rx_limited && ing_cred_reg[rx_frm_prio] < 0 |=> rx_dec_valid && rx_dec_drop)
    else $error("spent bucket did not drop");
  unlimited_pass_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    rx_frm_valid && ing_kbps[rx_frm_prio] == '0 |=> rx_dec_valid && !rx_dec_drop)
    else $error("unlimited frame dropped");
  mode_exempt_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    rx_frm_valid && !rx_counted |=> !rx_dec_drop)
    else $error("uncounted frame dropped");
  speed_ten_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    speed_10m && port2_ingress_rate_ctrl_reg[3:0] > SPEED10_MAX_CODE |-> ing_kbps[0] == '0)
    else $error("fast code limited at 10M");
  single_queue_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !multi_q && fifo_pop |-> eg_sel_prio == 2'h0 && eg_ok[0])
    else $error("single queue used other field");
  shape_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    fifo_valid && !eg_ok[eg_sel_prio] |=> fifo_valid && fifo_data == $past(fifo_data))
    else $error("held frame lost");
  out_stall_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    tx_out_valid && !tx_out_ready |=> tx_out_valid && $stable(tx_out_len) && $stable(tx_out_prio))
    else $error("output dropped under stall");
  read_one_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    reg_rd && reg_addr == ING_RATE_OFS |=> reg_rdata == $past(port2_ingress_rate_ctrl_reg) ##1 reg_rdata == '0
      || $past(reg_rd))
    else $error("read data wrong");

  // Verdict, egress output and register checks
  pass_credit_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    rx_frm_valid && !ing_cred_reg[rx_frm_prio][CRED_W-1] |=> rx_dec_valid && !rx_dec_drop)
    else $error("frame with credit dropped");
  verdict_idle_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !rx_frm_valid |=> !rx_dec_valid && !rx_dec_drop)
    else $error("verdict without frame");
  bcast_counted_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    rx_frm_valid && rx_frm_bcast |-> rx_counted)
    else $error("broadcast frame not counted");
  out_taken_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    tx_out_valid && tx_out_ready && !fifo_pop |=> !tx_out_valid)
    else $error("taken output still valid");
  wr_ingress_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    reg_wr && reg_addr == ING_RATE_OFS |=> port2_ingress_rate_ctrl_reg == $past(reg_wdata))
    else $error("ingress write lost");
  wr_egress_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    reg_wr && reg_addr == EG_RATE_OFS |=> port2_egress_rate_ctrl_reg == $past(reg_wdata))
    else $error("egress write lost");
  read_egress_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    reg_rd && reg_addr == EG_RATE_OFS |=> reg_rdata == $past(port2_egress_rate_ctrl_reg))
    else $error("egress read wrong");
endmodule : prl_port_rate_limiter

// ---- tb/prl_far_end.sv ----
// Egress sink model standing for the port 2 transmit path
module prl_far_end (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic stall,
  input wire logic tx_out_valid,
  input wire logic [10:0] tx_out_len,
  input wire logic [1:0] tx_out_prio,
  output logic tx_out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_reg;
  logic [12:0] got [$];
  // Ready pattern, low one cycle in three while stalling
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 2'h0;
      tx_out_ready <= 1'b1;
      got.delete();
    end else begin
      cnt_reg <= (cnt_reg == 2'h2) ? 2'h0 : cnt_reg + 2'h1;
      tx_out_ready <= !(stall && cnt_reg == 2'h1);
      if (tx_out_valid && tx_out_ready) begin
        got.push_back({tx_out_prio, tx_out_len});
      end
    end
  end
endmodule : prl_far_end

// ---- tb/testbench.sv ----
// Self-checking bench for the port 2 rate limiter
module testbench
  import prl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0] fld;
    logic [3:0] code;
    logic [1:0] prio;
    logic spd;
    logic [1:0] mode;
    logic [2:0] cls;
    logic exp;
  } prl_row_type;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] reg_addr = 16'h0, reg_wdata = 16'h0, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, speed_10m = 1'b0, stall = 1'b0;
  logic rx_frm_valid = 1'b0, rx_frm_bcast = 1'b0, rx_frm_mcast = 1'b0, rx_frm_flood = 1'b0;
  logic rx_dec_valid, rx_dec_drop, tx_in_valid = 1'b0, tx_in_ready, tx_out_valid, tx_out_ready;
  logic [10:0] rx_frm_len = 11'h0, tx_in_len = 11'h0, tx_out_len;
  logic [1:0] rx_frm_prio = 2'h0, tx_in_prio = 2'h0, tx_out_prio;
  int n_errors = 0;
  int cmp_count = 0;
  // Field, code, frame prio, 10M, mode, {bcast,mcast,flood}, third frame dropped
  prl_row_type rows [13] = '{'{3, 1, 3, 0, 0, 0, 1}, '{2, 15, 2, 0, 0, 0, 1}, '{1, 3, 1, 0, 0, 0, 1},
    '{0, 8, 0, 1, 0, 0, 1}, '{0, 9, 0, 1, 0, 0, 0}, '{2, 0, 2, 0, 0, 0, 0}, '{3, 1, 0, 0, 0, 0, 0},
    '{0, 1, 0, 0, 3, 4, 1}, '{0, 1, 0, 0, 3, 2, 0}, '{0, 1, 0, 0, 2, 2, 1}, '{0, 1, 0, 0, 2, 1, 0},
    '{0, 1, 0, 0, 1, 1, 1}, '{0, 1, 0, 0, 1, 0, 0}};

  always #5 clk_sys = ~clk_sys;

  prl_port_rate_limiter dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .speed_10m(speed_10m),
    .rx_frm_valid(rx_frm_valid), .rx_frm_len(rx_frm_len), .rx_frm_prio(rx_frm_prio),
    .rx_frm_bcast(rx_frm_bcast), .rx_frm_mcast(rx_frm_mcast), .rx_frm_flood(rx_frm_flood),
    .rx_dec_valid(rx_dec_valid), .rx_dec_drop(rx_dec_drop), .tx_in_valid(tx_in_valid),
    .tx_in_ready(tx_in_ready), .tx_in_len(tx_in_len), .tx_in_prio(tx_in_prio), .tx_out_valid(tx_out_valid),
    .tx_out_ready(tx_out_ready), .tx_out_len(tx_out_len), .tx_out_prio(tx_out_prio));

  prl_far_end far (.clk_sys(clk_sys), .resetn(resetn), .stall(stall), .tx_out_valid(tx_out_valid),
    .tx_out_len(tx_out_len), .tx_out_prio(tx_out_prio), .tx_out_ready(tx_out_ready));

  // Compare of word results
  task automatic chk_reg(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %0s expected %h seen %h", nm, e, g);
    end
  endtask : chk_reg

  // Compare of single-bit results
  task automatic chk_bit(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %0s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  // Counts and verdict, then stop
  task automatic summarize;
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  // Short reset in mid-run
  task automatic rst;
    @(posedge clk_sys);
    resetn <= 1'b0;
    @(posedge clk_sys);
    resetn <= 1'b1;
  endtask : rst

  // One-cycle register write
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // One-cycle register read, data taken in the following cycle
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // Ingress descriptor of 2047 bytes, verdict one cycle later
  task automatic rx(input logic [1:0] p, input logic [2:0] c, output logic d);
    @(posedge clk_sys);
    rx_frm_valid <= 1'b1;
    rx_frm_prio <= p;
    {rx_frm_bcast, rx_frm_mcast, rx_frm_flood} <= c;
    rx_frm_len <= 11'h7ff;
    @(posedge clk_sys);
    rx_frm_valid <= 1'b0;
    #1;
    chk_bit("rx_dec_valid", 1'b1, rx_dec_valid);
    d = rx_dec_drop;
  endtask : rx

  // Egress descriptor offer, held until taken, bounded
  task automatic tx(input logic [1:0] p, input logic [10:0] l, output bit ok);
    ok = 1'b0;
    @(posedge clk_sys);
    tx_in_valid <= 1'b1;
    tx_in_prio <= p;
    tx_in_len <= l;
    for (int i = 0; i < 16 && !ok; i++) begin
      @(posedge clk_sys);
      ok = (tx_in_ready === 1'b1);
    end
    tx_in_valid <= 1'b0;
    chk_bit("tx taken", 1'b1, ok);
  endtask : tx

  // Bounded wait for the sink to collect n frames
  task automatic wait_got(input int n, input int m);
    for (int i = 0; i < m && far.got.size() < n; i++) begin
      @(posedge clk_sys);
    end
  endtask : wait_got

  // Watchdog
  initial begin
    #200us;
    n_errors++;
    summarize();
  end

  // Main sequence
  initial begin
    bit ok;
    logic d;
    logic [15:0] v;
    int n;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(ING_RATE_OFS, v);
    chk_reg("ingress reset", ING_RATE_RST, v);
    rd(EG_RATE_OFS, v);
    chk_reg("egress reset", EG_RATE_RST, v);
    wr(ING_RATE_OFS, 16'ha5c3);
    rd(ING_RATE_OFS, v);
    chk_reg("ingress rw", 16'ha5c3, v);
    @(posedge clk_sys);
    #1;
    chk_reg("rdata idle", 16'h0, reg_rdata);
    wr(EG_RATE_OFS, 16'h3c5a);
    rd(EG_RATE_OFS, v);
    chk_reg("egress rw", 16'h3c5a, v);
    rd(16'h0600, v);
    chk_reg("unmapped", 16'h0, v);
    $display("test registers done");
    // Policing table: two frames spend the bucket, the third is judged
    foreach (rows[k]) begin
      rst();
      speed_10m <= rows[k].spd;
      wr(CFG_OFS, 16'h0010 | (16'(rows[k].mode) << 2));
      wr(ING_RATE_OFS, 16'(rows[k].code) << (4 * rows[k].fld));
      rx(rows[k].prio, rows[k].cls, d);
      chk_bit("first drop", 1'b0, d);
      rx(rows[k].prio, rows[k].cls, d);
      chk_bit("second drop", 1'b0, d);
      rx(rows[k].prio, rows[k].cls, d);
      chk_bit("third drop", rows[k].exp, d);
    end
    speed_10m <= 1'b0;
    $display("test ingress done");
    // Shaping per priority: third frame held, released when unlimited
    for (int p = 0; p < 4; p++) begin
      rst();
      wr(EG_RATE_OFS, 16'h0001 << (4 * p));
      repeat (3) tx(2'(p), 11'h7ff, ok);
      wait_got(3, 100);
      chk_reg("held count", 16'd2, 16'(far.got.size()));
      wr(EG_RATE_OFS, 16'h0000);
      wait_got(3, 50);
      chk_reg("released count", 16'd3, 16'(far.got.size()));
    end
    $display("test egress done");
    // Single queue, then FIFO fill and drain against a stalling sink
    rst();
    stall <= 1'b1;
    wr(CFG_OFS, 16'h0000);
    wr(EG_RATE_OFS, 16'h1000);
    repeat (3) tx(2'h3, 11'h7ff, ok);
    wait_got(3, 100);
    chk_reg("single queue p3", 16'd3, 16'(far.got.size()));
    wr(EG_RATE_OFS, 16'h0001);
    repeat (2) tx(2'h3, 11'h7ff, ok);
    wait_got(5, 100);
    tx(2'h3, 11'h7fe, ok);
    n = 0;
    for (int k = 0; k < 7; k++) begin
      tx(2'h3, 11'(k), ok);
      n += ok;
    end
    chk_reg("fifo accepted", 16'd7, 16'(n));
    rd(STATUS_OFS, v);
    chk_reg("status full", 16'h0110, v);
    chk_bit("fifo refuses", 1'b0, tx_in_ready);
    chk_reg("single queue p0", 16'd5, 16'(far.got.size()));
    wr(EG_RATE_OFS, 16'h0000);
    wait_got(13, 300);
    chk_reg("drained", 16'd13, 16'(far.got.size()));
    chk_reg("held first", 16'h1ffe, 16'(far.got[5]));
    for (int k = 0; k < 7; k++) begin
      chk_reg("order", 16'h1800 | 16'(k), 16'(far.got[6 + k]));
    end
    $display("test single queue done");
    summarize();
  end
endmodule : testbench
